// ### common/hcs_pkg.sv
// Purpose: shared constants and types for the hole-count shear targeting block
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes: distances are in encoder counts after scaling
`default_nettype none
package hcs_pkg;
   localparam int DIST_W = 24;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SPACING = 8'h04;
   localparam logic [7:0] OFS_NOHOLE = 8'h08;
   localparam logic [7:0] OFS_DET2SHEAR = 8'h0C;
   localparam logic [7:0] OFS_ITEM = 8'h10;
   localparam logic [7:0] OFS_OFFSET = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_MASK = 8'h1C;
   localparam logic [7:0] OFS_POS = 8'h20;
   localparam logic [7:0] OFS_SCALE = 8'h24;
   // ctrl fields
   localparam int CTRL_RUN = 0;
   localparam int CTRL_HOLEMODE = 1;
   localparam int CTRL_ACTHIGH = 2;
   localparam int CTRL_USE_LSB = 3;
   localparam int CTRL_USE_W = 2;
   localparam int CTRL_CLRERR = 8;
   // status bits
   localparam int ST_HOLE = 0;
   localparam int ST_FIRE = 1;
   localparam int ST_NOHOLE = 2;
   localparam int ST_W = 3;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [1:0] AXI_OKAY = 2'b00;
   localparam logic [1:0] AXI_SLVERR = 2'b10;
   localparam logic [15:0] SCALE_RST = 16'h0001;

   typedef enum logic [1:0] {
      HCS_USE_EDGE = 2'b00,
      HCS_USE_ONEHOLE = 2'b01,
      HCS_USE_COUNT = 2'b10
   } hcs_use_t;

   typedef enum logic [1:0] {
      HCS_IDLE = 2'b00,
      HCS_SEEK = 2'b01,
      HCS_TARGET = 2'b11,
      HCS_STOP = 2'b10
   } hcs_state_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } hcs_wreq_t;
endpackage
`default_nettype wire

// ### hw/hole_count_shear.sv
// Purpose: hole-detect option logic: count holes or find an edge, target the shear
// Assumes: encoder steps arrive as a one-cycle pulse; detector input is asynchronous
// Notes: registers over AXI4-Lite; one level interrupt
//
// Summary of operation
// - detect input finds leading edge, one hole, or counts a hole series.
// - mode picks hole counting or standard programmed part length cutting.
// - polarity picks active-low or active-high detect; active-low is default.
// - after an accepted hole, ignore detects until minimum spacing travelled.
// - stop line with error when past-shear plus detector distance exceeds limit.
// - detector-to-shear distance converts detection point to shear firing point.
// - hole-mode item carries hole count and offset; cut is offset past last hole.
// - offset counts from leading edge of the last counted hole.
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module hcs_hole_count_shear
   import hcs_pkg::*;
#(
   parameter int CNT_W = 16
)(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic fiberOpticDetector,
   input wire logic encStep,
   output logic shearFire,
   output logic lineStop,
   output logic irq,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // the position register shows eight bits of the hole count
   if (CNT_W < 8 || CNT_W > 32) begin : g_cnt_w_check
      $error("CNT_W out of range");
   end

   // pin idles high for the default active-low polarity: no false edge after reset
   localparam logic [2:0] SYNC_RST = 3'b011;
   // no register sits here, so a refused address falls to the default arm
   localparam logic [7:0] OFS_NONE = 8'hFF;

   typedef struct packed {
      logic [2:0] sync;
      logic [31:0] ctrl;
      logic [DIST_W-1:0] spacing;
      logic [DIST_W-1:0] noHole;
      logic [DIST_W-1:0] det2Shear;
      logic [CNT_W-1:0] holeTarget;
      logic [DIST_W-1:0] offset;
      logic [ST_W-1:0] status;
      logic [ST_W-1:0] mask;
      logic [15:0] scale;
      logic [15:0] scaleCnt;
      logic [DIST_W-1:0] travel;
      logic [DIST_W-1:0] sinceHole;
      logic [DIST_W-1:0] toFire;
      logic [CNT_W-1:0] holes;
      hcs_state_t st;
      logic fire;
      logic stop;
      logic awHave;
      logic wHave;
      logic [31:0] awAddr;
      hcs_wreq_t wr;
      logic bValid;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic [1:0] bResp;
   } hcs_regs_t;

   hcs_regs_t q, d;

   function automatic logic mapped(input logic [31:0] a);
      mapped = (a[7:0] <= OFS_SCALE) && (a[1:0] == 2'b00) && (a[31:8] == 24'h00_0000);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   logic detRaw, detLevel, detRise, unitStep, doWrite, doRead, inSpacing;
   logic [31:0] wv;
   logic [ST_W-1:0] evt;
   hcs_use_t useSel;

   assign detRaw = q.sync[1];
   // active-low default: hole is seen when the input is pulled to common
   assign detLevel = q.ctrl[CTRL_ACTHIGH] ? detRaw : ~detRaw;
   assign detRise = detLevel & ~q.sync[2];
   assign useSel = hcs_use_t'(q.ctrl[CTRL_USE_LSB +: CTRL_USE_W]);
   // unit step only after the scale divider: distances are in length units
   assign unitStep = encStep && (q.scaleCnt + 16'h0001 >= q.scale);
   assign inSpacing = q.sinceHole < q.spacing;

   always_comb begin
      d = q;
      evt = '0;
      wv = '0;
      d.sync = {detLevel, q.sync[0], fiberOpticDetector};
      d.fire = 1'b0;
      // scale counter
      if (encStep) begin
         d.scaleCnt = unitStep ? 16'h0000 : q.scaleCnt + 16'h0001;
      end
      if (unitStep && q.st != HCS_IDLE) begin
         d.travel = q.travel + DIST_W'(1);
         if (inSpacing) d.sinceHole = q.sinceHole + DIST_W'(1);
      end
      unique case (q.st)
         HCS_IDLE: begin
            if (q.ctrl[CTRL_RUN] && !q.stop) begin
               d.st = HCS_SEEK;
               d.holes = '0;
               d.travel = '0;
               d.sinceHole = q.spacing;
            end
         end
         HCS_SEEK: begin
            if (!q.ctrl[CTRL_RUN]) begin
               d.st = HCS_IDLE;
            end else if (!q.ctrl[CTRL_HOLEMODE]) begin
               // standard: cut at programmed part length after the start
               if (q.travel >= q.offset) begin
                  d.fire = 1'b1;
                  d.travel = '0;
                  evt[ST_FIRE] = 1'b1;
               end
            end else if (detRise && !inSpacing) begin
               evt[ST_HOLE] = 1'b1;
               d.sinceHole = '0;
               d.holes = q.holes + CNT_W'(1);
               // edge and single hole need one event; count needs the full series
               if (useSel != HCS_USE_COUNT ||
                   q.holes + CNT_W'(1) >= q.holeTarget) begin
                  d.st = HCS_TARGET;
                  // leading edge of the hole is now at the detector
                  d.toFire = q.det2Shear + q.offset;
               end
            end else if (q.travel + q.det2Shear > q.noHole) begin
               d.st = HCS_STOP;
               d.stop = 1'b1;
               evt[ST_NOHOLE] = 1'b1;
            end
         end
         HCS_TARGET: begin
            if (unitStep) d.toFire = q.toFire - DIST_W'(1);
            if (q.toFire == '0) begin
               d.fire = 1'b1;
               evt[ST_FIRE] = 1'b1;
               d.st = HCS_SEEK;
               d.holes = '0;
               d.travel = '0;
            end
         end
         HCS_STOP: begin
            if (q.ctrl[CTRL_CLRERR]) begin
               d.stop = 1'b0;
               d.st = HCS_IDLE;
            end
         end
      endcase
      d.ctrl[CTRL_CLRERR] = 1'b0;

      // AXI4-Lite write path
      if (s_axi_awvalid && !q.awHave) begin
         d.awHave = 1'b1;
         d.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !q.wHave) begin
         d.wHave = 1'b1;
         d.wr.data = s_axi_wdata;
         d.wr.strb = s_axi_wstrb;
      end
      doWrite = q.awHave && q.wHave && !q.bValid;
      if (doWrite) begin
         d.awHave = 1'b0;
         d.wHave = 1'b0;
         d.bValid = 1'b1;
         d.bResp = mapped(q.awAddr) ? AXI_OKAY : AXI_SLVERR;
         unique case (mapped(q.awAddr) ? q.awAddr[7:0] : OFS_NONE)
            OFS_CTRL: d.ctrl = merge(q.ctrl, q.wr.data, q.wr.strb);
            OFS_SPACING: begin
               wv = merge(32'(q.spacing), q.wr.data, q.wr.strb);
               d.spacing = wv[DIST_W-1:0];
            end
            OFS_NOHOLE: begin
               wv = merge(32'(q.noHole), q.wr.data, q.wr.strb);
               d.noHole = wv[DIST_W-1:0];
            end
            OFS_DET2SHEAR: begin
               wv = merge(32'(q.det2Shear), q.wr.data, q.wr.strb);
               d.det2Shear = wv[DIST_W-1:0];
            end
            OFS_ITEM: begin
               wv = merge(32'(q.holeTarget), q.wr.data, q.wr.strb);
               d.holeTarget = wv[CNT_W-1:0];
            end
            OFS_OFFSET: begin
               wv = merge(32'(q.offset), q.wr.data, q.wr.strb);
               d.offset = wv[DIST_W-1:0];
            end
            OFS_STATUS: d.status = q.status & ~q.wr.data[ST_W-1:0];
            OFS_MASK: d.mask = q.wr.data[ST_W-1:0];
            OFS_SCALE: begin
               wv = merge(32'(q.scale), q.wr.data, q.wr.strb);
               d.scale = wv[15:0];
            end
            default: ;
         endcase
      end
      // set wins over a same-cycle clear
      d.status = d.status | evt;
      if (q.bValid && s_axi_bready) d.bValid = 1'b0;

      // read path
      doRead = s_axi_arvalid && !q.rValid;
      if (doRead) begin
         d.rValid = 1'b1;
         d.rResp = mapped(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
         unique case (mapped(s_axi_araddr) ? s_axi_araddr[7:0] : OFS_NONE)
            OFS_CTRL: d.rData = q.ctrl;
            OFS_SPACING: d.rData = 32'(q.spacing);
            OFS_NOHOLE: d.rData = 32'(q.noHole);
            OFS_DET2SHEAR: d.rData = 32'(q.det2Shear);
            OFS_ITEM: d.rData = 32'(q.holeTarget);
            OFS_OFFSET: d.rData = 32'(q.offset);
            OFS_STATUS: d.rData = 32'(q.status);
            OFS_MASK: d.rData = 32'(q.mask);
            OFS_POS: d.rData = {6'h00, q.st, q.holes[7:0], 16'(q.travel)};
            OFS_SCALE: d.rData = 32'(q.scale);
            default: d.rData = 32'h0000_0000;
         endcase
      end else if (q.rValid && s_axi_rready) begin
         d.rValid = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         q <= '0;
         q.ctrl <= CTRL_RST;
         q.sync <= SYNC_RST;
         q.scale <= SCALE_RST;
         q.st <= HCS_IDLE;
      end else begin
         q <= d;
      end
   end

   assign shearFire = q.fire;
   assign lineStop = q.stop;
   assign irq = |(q.status & q.mask);
   assign s_axi_awready = !q.awHave;
   assign s_axi_wready = !q.wHave;
   assign s_axi_bvalid = q.bValid;
   assign s_axi_bresp = q.bResp;
   assign s_axi_arready = !q.rValid;
   assign s_axi_rvalid = q.rValid;
   assign s_axi_rdata = q.rData;
   assign s_axi_rresp = q.rResp;

   // checks
   spacing_block_a: assert property (@(posedge clk_sys) disable iff (reset)
      (q.st == HCS_SEEK && q.ctrl[CTRL_HOLEMODE] && inSpacing)
         |=> q.holes == $past(q.holes))
      else $error("hole accepted inside spacing");
   nohole_stop_a: assert property (@(posedge clk_sys) disable iff (reset)
      (q.st == HCS_SEEK && q.ctrl[CTRL_RUN] && q.ctrl[CTRL_HOLEMODE] && !detRise
       && q.travel + q.det2Shear > q.noHole) |=> lineStop && q.status[ST_NOHOLE])
      else $error("no-hole limit did not stop line");
   target_load_a: assert property (@(posedge clk_sys) disable iff (reset)
      $rose(q.st == HCS_TARGET) |-> q.toFire == $past(q.det2Shear) + $past(q.offset))
      else $error("firing distance wrong");
   fire_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
      (q.st == HCS_TARGET && q.toFire == '0) |=> shearFire)
      else $error("shear not fired at target");
   fire_pulse_a: assert property (@(posedge clk_sys) disable iff (reset)
      shearFire |=> !shearFire) else $error("fire longer than one cycle");
   count_series_a: assert property (@(posedge clk_sys) disable iff (reset)
      (q.st == HCS_SEEK && $past(q.st) == HCS_SEEK && useSel == HCS_USE_COUNT
       && q.holes < q.holeTarget) |=> (q.st != HCS_TARGET
       || $past(q.holes) + CNT_W'(1) >= $past(q.holeTarget)))
      else $error("target before hole count reached");
   std_mode_a: assert property (@(posedge clk_sys) disable iff (reset)
      (!q.ctrl[CTRL_HOLEMODE] && q.st == HCS_SEEK && q.ctrl[CTRL_RUN])
         |=> q.st != HCS_TARGET) else $error("target in standard mode");
   polarity_a: assert property (@(posedge clk_sys) disable iff (reset)
      (q.st == HCS_SEEK && q.ctrl[CTRL_RUN] && q.ctrl[CTRL_HOLEMODE] && !inSpacing
       && $changed(q.sync[1]) && q.sync[1] == q.ctrl[CTRL_ACTHIGH]
       && $stable(q.ctrl[CTRL_ACTHIGH])) |=> q.status[ST_HOLE])
      else $error("detect at active level not taken");
   travel_step_a: assert property (@(posedge clk_sys) disable iff (reset)
      (q.st == HCS_SEEK && $past(q.st) == HCS_SEEK && !$past(unitStep)
       && !$past(q.fire) && !q.fire) |-> q.travel == $past(q.travel))
      else $error("travel moved without a unit step");
endmodule
`default_nettype wire

// ### bench/hcs_det_model.sv
// Purpose: optical hole or edge detector switch seen from the detect pin
// Assumes: the bench says when a hole or edge sits under the eye
// Notes: idle level is the inactive level of the chosen polarity
`timescale 1ns/1ps
`default_nettype none
module hcs_det_model (
   input wire logic inHole,
   input wire logic actHigh,
   output logic fiberOpticDetector
);
   // active low pulls to common on a hole; active high floats high
   assign fiberOpticDetector = inHole ? actHigh : !actHigh;
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Purpose: self-checking bench for the hole-count shear block
// Assumes: one encoder count per length unit unless scale is changed
// Notes: encoder pulses spaced three cycles so the detect synchroniser keeps up
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import hcs_pkg::*;
   typedef struct {logic [7:0] a; logic [31:0] v; logic [1:0] r;} hcs_row_t;
   logic clk_sys = 1'b0, reset = 1'b1, encStep = 1'b0, inHole = 1'b0, actHigh = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic fiberOpticDetector, shearFire, lineStop, irq, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [31:0] s_axi_rdata, rdv, base;
   logic [31:0] fireCnt = 32'h0;
   int bad_count = 0;
   int cmp_count = 0;
   // reset values and refused addresses: unmapped and unaligned read as zero with an error
   hcs_row_t rows [6] = '{'{OFS_CTRL, CTRL_RST, AXI_OKAY}, '{OFS_STATUS, 32'h0, AXI_OKAY},
      '{OFS_MASK, 32'h0, AXI_OKAY}, '{OFS_SCALE, {16'h0, SCALE_RST}, AXI_OKAY},
      '{8'h28, 32'h0, AXI_SLVERR}, '{8'h02, 32'h0, AXI_SLVERR}};

   hcs_det_model hcs_det_model_inst (.inHole(inHole), .actHigh(actHigh),
      .fiberOpticDetector(fiberOpticDetector));
   hcs_hole_count_shear hcs_hole_count_shear_inst (.clk_sys(clk_sys), .reset(reset),
      .fiberOpticDetector(fiberOpticDetector), .encStep(encStep), .shearFire(shearFire),
      .lineStop(lineStop), .irq(irq), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));

   initial begin
      forever #12.5 clk_sys = !clk_sys;
   end

   always @(posedge clk_sys) begin
      if (shearFire === 1'b1) begin
         fireCnt <= fireCnt + 32'h1;
      end
   end

   task automatic final_report;
      if (bad_count == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 100);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 100) bad_count++;
   endtask

   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge clk_sys);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 100);
      rdv = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 100) bad_count++;
   endtask

   task automatic steps(input int k);
      repeat (k) begin
         @(posedge clk_sys);
         encStep <= 1'b1;
         @(posedge clk_sys);
         encStep <= 1'b0;
         @(posedge clk_sys);
      end
   endtask

   // a hole that flickers again two counts later, well inside the spacing
   task automatic hole;
      inHole <= 1'b1;
      steps(1);
      inHole <= 1'b0;
      steps(1);
      inHole <= 1'b1;
      steps(1);
      inHole <= 1'b0;
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      final_report();
   end

   initial begin
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      foreach (rows[i]) begin
         rd(rows[i].a);
         check("rdata", rows[i].v, rdv);
         check("rresp", {30'h0, rows[i].r}, {30'h0, rsp});
      end
      wr(OFS_SPACING, 32'h5);
      wr(OFS_NOHOLE, 32'h64);
      wr(OFS_DET2SHEAR, 32'h4);
      wr(OFS_OFFSET, 32'h2);
      wr(OFS_ITEM, 32'h3);
      wr(OFS_MASK, 32'h7);
      wr(OFS_CTRL, 32'h13);
      hole();
      steps(6);
      rd(OFS_POS);
      check("holes", 32'h1, {24'h0, rdv[23:16]});
      hole();
      steps(6);
      hole();
      steps(1);
      check("fire early", 32'h0, fireCnt);
      steps(5);
      check("fire", 32'h1, fireCnt);
      rd(OFS_STATUS);
      check("status", 32'h3, rdv & 32'h3);
      check("irq set", 32'h1, {31'h0, irq});
      wr(OFS_STATUS, 32'h3);
      check("irq clear", 32'h0, {31'h0, irq});
      // no hole within the limit: detector distance counts toward it
      wr(OFS_NOHOLE, 32'h14);
      steps(30);
      check("stop", 32'h1, {31'h0, lineStop});
      rd(OFS_STATUS);
      check("nohole bit", 32'h4, rdv & 32'h4);
      wr(OFS_MASK, 32'h0);
      check("irq masked", 32'h0, {31'h0, irq});
      wr(OFS_MASK, 32'h4);
      check("irq unmasked", 32'h1, {31'h0, irq});
      wr(OFS_STATUS, 32'h4);
      wr(OFS_CTRL, 32'h100);
      // the error clears one cycle after the control write lands
      @(posedge clk_sys);
      check("stop cleared", 32'h0, {31'h0, lineStop});
      wr(OFS_NOHOLE, 32'h3E8);
      wr(OFS_ITEM, 32'h1);
      // edge use with active low, one-hole use with active high
      for (int i = 0; i < 2; i++) begin
         base = fireCnt;
         wr(OFS_CTRL, 32'h0);
         actHigh <= i[0];
         wr(OFS_CTRL, 32'h3 | (i << 3) | (i << 2));
         inHole <= 1'b1;
         steps(1);
         inHole <= 1'b0;
         steps(3);
         check("use early", base, fireCnt);
         steps(5);
         check("use fire", base + 32'h1, fireCnt);
      end
      // standard mode: two counts a unit, part length five units
      wr(OFS_CTRL, 32'h0);
      wr(OFS_SCALE, 32'h2);
      wr(OFS_OFFSET, 32'h5);
      base = fireCnt;
      wr(OFS_CTRL, 32'h1);
      steps(8);
      check("std early", base, fireCnt);
      steps(4);
      check("std fire", base + 32'h1, fireCnt);
      // write responses: refused address, then a mapped one
      wr(8'h28, 32'h1);
      check("bresp bad", {30'h0, AXI_SLVERR}, {30'h0, rsp});
      wr(OFS_MASK, 32'h2);
      check("bresp ok", {30'h0, AXI_OKAY}, {30'h0, rsp});
      check("irq fire", 32'h1, {31'h0, irq});
      // reset in mid-run while the line is seeking
      reset <= 1'b1;
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      check("reset stop", 32'h0, {31'h0, lineStop});
      check("reset irq", 32'h0, {31'h0, irq});
      check("reset awready", 32'h1, {31'h0, s_axi_awready});
      rd(OFS_MASK);
      check("reset mask", 32'h0, rdv);
      rd(OFS_CTRL);
      check("reset ctrl", CTRL_RST, rdv);
      final_report();
   end
endmodule
`default_nettype wire
